// ---- pkg/dsm_pkg.sv ----
// shared constants and types for the dual-channel safety input monitor
package dsm_pkg;
  // =========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMING = 8'h04;
  localparam logic [7:0] OFF_SELECT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_FAULT = 8'h10;
  // =========================================================
  // reset values
  localparam logic [3:0] RST_FILTER = 4'h1;
  localparam logic [5:0] RST_DISC = 6'h02;
  localparam logic [1:0] RST_CFG = 2'h0;
  localparam logic [4:0] RST_SEL_A = 5'h00;
  localparam logic [4:0] RST_SEL_B = 5'h01;
  localparam logic [1:0] RST_PT = 2'h0;
  localparam logic [2:0] RST_SRC_A = 3'h0;
  localparam logic [2:0] RST_SRC_B = 3'h1;
  // =========================================================
  // limits
  localparam logic [5:0] DISC_MAX = 6'h3c;
  localparam int NUM_TERM = 18;
  localparam logic [4:0] LAST_EMBEDDED = 5'h0b;
  // =========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int FILTER_UNIT_MS = 25;
  localparam int DISC_UNIT_MS = 50;
  localparam int FILTER_UNIT_CYC = CLK_HZ / 1000 * FILTER_UNIT_MS;
  localparam int DISC_UNIT_CYC = CLK_HZ / 1000 * DISC_UNIT_MS;
  localparam int SELFTEST_CYC = 16;
  // =========================================================
  // input configuration
  localparam logic [1:0] CFG_TWO_NC = 2'h0;
  localparam logic [1:0] CFG_TWO_OSSD = 2'h1;
  localparam logic [1:0] CFG_ONE_NC = 2'h2;
  localparam logic [1:0] PT_OFF = 2'h0;
  localparam logic [1:0] PT_TWO_SOURCES = 2'h2;

  typedef enum logic [2:0] {
    ST_SELFTEST = 3'b001,
    ST_FIRST = 3'b010,
    ST_RUN = 3'b100
  } dsm_mode_e;

  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] pulse_test;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [3:0] filter;
    logic [5:0] disc;
    logic legacy;
    logic download;
  } dsm_cfg_s;
endpackage

// ---- src/dsm_filter.sv ----
// one channel input filter: accepts a level after it stays stable
`timescale 1ns/1ps
`default_nettype none
module dsm_filter #(
  parameter int UNIT_CYC = 1250000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw unsynchronised level and setting
  input wire logic raw,
  input wire logic [3:0] setting,
  // filtered level
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [31:0] cnt;
    logic level;
  } dsm_filt_s;
  dsm_filt_s r;
  dsm_filt_s next_r;
  logic [31:0] limit;

  // filter length in cycles
  assign limit = 32'(setting) * 32'(UNIT_CYC);

  // two-stage sync then stability count
  always_comb begin
    next_r = r;
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.prev = r.s2;
    // RQ20: edge restarts timer
    if (r.s2 != r.prev) begin
      next_r.cnt = 32'h0;
    end else if (r.cnt < limit) begin
      next_r.cnt = r.cnt + 32'h1;
    end
    if (r.s2 == r.prev && r.cnt >= limit) begin
      next_r.level = r.s2;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.level;
endmodule
`default_nettype wire

// ---- src/dsm_monitor.sv ----
// dual-channel safety input monitor with AXI4-Lite registers
// Behaviour
// RQ1: run mode only after self-tests pass
// RQ2: legacy first scan mismatch sets channel fault
// RQ3: current mode checks mismatch by discrepancy only
// RQ4: disabled discrepancy, entry mismatch gives no fault
// RQ5: enabled discrepancy entry fault per behaviour option
// RQ6: OSSD blip at entry, output rises later
// RQ7: disabled discrepancy, single drop lowers output
// RQ8: restore needs both channels low then high
// RQ9: quick single drop and return channel fault
// RQ10: single drop beyond discrepancy time faults
// RQ11: late return sets both faults
// RQ12: channel fault cleared by low-high cycle
// RQ13: discrepancy fault cleared by low-high cycle
// RQ14: one cycle clears both faults together
// RQ15: select two NC, two OSSD, one NC
// RQ16: pulse test off or two sources
// RQ17: channel from embedded or multipurpose terminals
// RQ18: filter time is setting times 25 ms
// RQ19: discrepancy 0 to 3 s, 50 ms
// RQ20: each edge restarts filter timer
// RQ21: channel fault forces output off
// RQ22: output high only when healthy and armed
// RQ23: separate sticky fault flags
`timescale 1ns/1ps
`default_nettype none
module dsm_monitor #(
  parameter int FILTER_UNIT = dsm_pkg::FILTER_UNIT_CYC,
  parameter int DISC_UNIT = dsm_pkg::DISC_UNIT_CYC,
  parameter int SELFTEST = dsm_pkg::SELFTEST_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // terminals and self-test
  input wire logic [dsm_pkg::NUM_TERM-1:0] terminals,
  input wire logic selftest_ok,
  // monitor result
  output logic monitor_block_output,
  output logic channel_fault,
  output logic discrepancy_fault,
  output logic [2:0] test_source_a,
  output logic [2:0] test_source_b,
  output logic test_pulse_enable,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    dsm_pkg::dsm_mode_e mode;
    logic [7:0] st_cnt;
    dsm_pkg::dsm_cfg_s cfg;
    logic [31:0] dcnt;
    logic dactive;
    logic chf;
    logic dcf;
    logic pend;
    logic entry;
    logic lowseen;
    logic outq;
    logic prev_a;
    logic prev_b;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dsm_state_s;
  dsm_state_s r;
  dsm_state_s next_r;
  logic raw_a;
  logic raw_b;
  logic fa;
  logic fb;
  logic two_ch;
  logic disc_en;
  logic [31:0] disc_limit;

  // =========================================================
  // terminal selection
  // RQ17: terminal index select
  function automatic logic pick(input logic [dsm_pkg::NUM_TERM-1:0] t, input logic [4:0] s);
    logic v;
    v = 1'b0;
    if (s < 5'(dsm_pkg::NUM_TERM)) begin
      v = t[s];
    end
    return v;
  endfunction

  // register offset decode
  function automatic logic mapped(input logic [7:0] a);
    return a == dsm_pkg::OFF_CTRL || a == dsm_pkg::OFF_TIMING || a == dsm_pkg::OFF_SELECT ||
           a == dsm_pkg::OFF_STATUS || a == dsm_pkg::OFF_FAULT;
  endfunction

  assign raw_a = pick(terminals, r.cfg.sel_a);
  // RQ15: single contact mirrors first
  assign raw_b = (r.cfg.cfg == dsm_pkg::CFG_ONE_NC) ? raw_a : pick(terminals, r.cfg.sel_b);
  assign two_ch = r.cfg.cfg != dsm_pkg::CFG_ONE_NC;
  // RQ19: zero disables check
  assign disc_en = two_ch && r.cfg.disc != 6'h00;
  assign disc_limit = 32'(r.cfg.disc) * 32'(DISC_UNIT);

  // =========================================================
  // channel filters
  // RQ18: 25 ms filter units
  dsm_filter #(.UNIT_CYC(FILTER_UNIT)) u_filt_a (
    .clk(clk),
    .rst_n(rst_n),
    .raw(raw_a),
    .setting(r.cfg.filter),
    .level(fa)
  );
  dsm_filter #(.UNIT_CYC(FILTER_UNIT)) u_filt_b (
    .clk(clk),
    .rst_n(rst_n),
    .raw(raw_b),
    .setting(r.cfg.filter),
    .level(fb)
  );

  // =========================================================
  // monitor and bus next state
  always_comb begin
    next_r = r;
    next_r.prev_a = fa;
    next_r.prev_b = fb;
    case (r.mode)
      dsm_pkg::ST_SELFTEST: begin
        next_r.outq = 1'b0;
        // RQ1: self-test gates run
        if (selftest_ok && r.st_cnt >= 8'(SELFTEST)) begin
          next_r.mode = dsm_pkg::ST_FIRST;
        end else if (selftest_ok) begin
          next_r.st_cnt = r.st_cnt + 8'h01;
        end else begin
          next_r.st_cnt = 8'h00;
        end
      end
      dsm_pkg::ST_FIRST: begin
        next_r.mode = dsm_pkg::ST_RUN;
        next_r.pend = fa != fb;
        next_r.entry = fa != fb;
        next_r.lowseen = 1'b0;
        // RQ2: legacy first scan test
        if (r.cfg.legacy && two_ch && fa != fb) begin
          next_r.chf = 1'b1;
        end
        // RQ3: current defers to discrepancy
        // RQ5: entry mismatch starts timer
        if (disc_en && fa != fb) begin
          next_r.dactive = 1'b1;
          next_r.dcnt = 32'h0;
        end
        // RQ4: no output on entry mismatch
        next_r.outq = 1'b0;
      end
      dsm_pkg::ST_RUN: begin
        // discrepancy timer runs while channels disagree
        if (disc_en && fa != fb) begin
          if (!r.dactive) begin
            next_r.dactive = 1'b1;
            next_r.dcnt = 32'h0;
          end else if (r.dcnt < disc_limit) begin
            next_r.dcnt = r.dcnt + 32'h1;
          end
          // RQ10: mismatch outlasts window
          // RQ5: entry mismatch persists
          if (r.dactive && r.dcnt >= disc_limit) begin
            next_r.dcf = 1'b1;
          end
        end else begin
          next_r.dactive = 1'b0;
        end
        // single-channel drop arms the pending state
        // RQ7: drop without fault when disabled
        if (r.prev_a && r.prev_b && (fa != fb)) begin
          next_r.pend = 1'b1;
          next_r.entry = 1'b0;
          next_r.lowseen = 1'b0;
        end
        // RQ9: return within window
        // RQ11: late return also channel fault
        // entry mismatch is judged by the legacy first scan and discrepancy, never here
        if (disc_en && r.pend && !r.entry && !r.lowseen && fa && fb &&
            !(r.prev_a && r.prev_b)) begin
          next_r.chf = 1'b1;
        end
        // RQ8: both low arms recovery
        if (!fa && !fb) begin
          next_r.lowseen = 1'b1;
        end
        // RQ12: clear channel fault
        // RQ13: clear discrepancy fault
        // RQ14: one cycle clears both
        if (r.lowseen && fa && fb) begin
          next_r.chf = 1'b0;
          next_r.dcf = 1'b0;
          next_r.pend = 1'b0;
          next_r.entry = 1'b0;
          next_r.lowseen = 1'b0;
        end
        // RQ6: entry blip recovers on agreement
        if (r.pend && r.entry && !r.chf && !r.dcf && !r.cfg.legacy && fa && fb &&
            r.cfg.cfg == dsm_pkg::CFG_TWO_OSSD) begin
          next_r.pend = 1'b0;
          next_r.entry = 1'b0;
        end
        // RQ21: channel fault forces off
        // RQ22: output when healthy
        next_r.outq = fa && fb && !next_r.chf && !next_r.dcf && !next_r.pend;
      end
      default: begin
        next_r.mode = dsm_pkg::ST_SELFTEST;
      end
    endcase
    // a download restarts through self-test
    if (r.cfg.download) begin
      next_r.mode = dsm_pkg::ST_SELFTEST;
      next_r.st_cnt = 8'h00;
      next_r.cfg.download = 1'b0;
      next_r.outq = 1'b0;
      next_r.chf = 1'b0;
      next_r.dcf = 1'b0;
      next_r.pend = 1'b0;
      next_r.entry = 1'b0;
      next_r.dactive = 1'b0;
    end
    // write channel capture
    if (s_axi_awvalid && !r.aw_got) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.awaddr) ? 2'h0 : 2'h2;
      if (r.awaddr == dsm_pkg::OFF_CTRL && r.wstrb[0]) begin
        // RQ15: input configuration
        if (r.wdata[1:0] != 2'h3) begin
          next_r.cfg.cfg = r.wdata[1:0];
        end
        // RQ16: pulse test sources default next
        if (r.wdata[3:2] == dsm_pkg::PT_OFF || r.wdata[3:2] == dsm_pkg::PT_TWO_SOURCES) begin
          next_r.cfg.pulse_test = r.wdata[3:2];
        end
        next_r.cfg.legacy = r.wdata[4];
        next_r.cfg.download = r.wdata[5];
      end
      if (r.awaddr == dsm_pkg::OFF_CTRL && r.wstrb[1]) begin
        next_r.cfg.src_a = r.wdata[10:8];
        next_r.cfg.src_b = r.wdata[14:12];
      end
      if (r.awaddr == dsm_pkg::OFF_TIMING && r.wstrb[0]) begin
        next_r.cfg.filter = r.wdata[3:0];
      end
      // RQ19: clamp to three seconds
      if (r.awaddr == dsm_pkg::OFF_TIMING && r.wstrb[1]) begin
        next_r.cfg.disc = (r.wdata[13:8] > dsm_pkg::DISC_MAX) ? dsm_pkg::DISC_MAX : r.wdata[13:8];
      end
      if (r.awaddr == dsm_pkg::OFF_SELECT && r.wstrb[0]) begin
        next_r.cfg.sel_a = r.wdata[4:0];
      end
      if (r.awaddr == dsm_pkg::OFF_SELECT && r.wstrb[1]) begin
        next_r.cfg.sel_b = r.wdata[12:8];
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        dsm_pkg::OFF_CTRL: next_r.rdata = {17'h0, r.cfg.src_b, 1'b0, r.cfg.src_a, 2'h0,
                                           r.cfg.download, r.cfg.legacy, r.cfg.pulse_test,
                                           r.cfg.cfg};
        dsm_pkg::OFF_TIMING: next_r.rdata = {18'h0, r.cfg.disc, 4'h0, r.cfg.filter};
        dsm_pkg::OFF_SELECT: next_r.rdata = {19'h0, r.cfg.sel_b, 3'h0, r.cfg.sel_a};
        dsm_pkg::OFF_STATUS: next_r.rdata = {24'h0, fb, fa, r.pend, r.outq, 1'b0, r.mode};
        // RQ23: separate sticky flags
        dsm_pkg::OFF_FAULT: next_r.rdata = {30'h0, r.dcf, r.chf};
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // =========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.mode <= dsm_pkg::ST_SELFTEST;
      r.cfg.cfg <= dsm_pkg::RST_CFG;
      r.cfg.pulse_test <= dsm_pkg::RST_PT;
      r.cfg.src_a <= dsm_pkg::RST_SRC_A;
      r.cfg.src_b <= dsm_pkg::RST_SRC_B;
      r.cfg.sel_a <= dsm_pkg::RST_SEL_A;
      r.cfg.sel_b <= dsm_pkg::RST_SEL_B;
      r.cfg.filter <= dsm_pkg::RST_FILTER;
      r.cfg.disc <= dsm_pkg::RST_DISC;
    end else begin
      r <= next_r;
    end
  end

  // =========================================================
  // outputs
  assign monitor_block_output = r.outq;
  assign channel_fault = r.chf;
  assign discrepancy_fault = r.dcf;
  assign test_source_a = r.cfg.src_a;
  assign test_source_b = r.cfg.src_b;
  assign test_pulse_enable = r.cfg.pulse_test == dsm_pkg::PT_TWO_SOURCES;
  assign s_axi_awready = !r.aw_got;
  assign s_axi_wready = !r.w_got;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule
`default_nettype wire

// ---- dv/dsm_monitor_sva.sv ----
// concurrent checks on the safety input monitor ports
`timescale 1ns/1ps
`default_nettype none
module dsm_monitor_sva #(
  parameter int FILTER_UNIT = 4,
  parameter int SELFTEST = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs and monitor result
  input wire logic [dsm_pkg::NUM_TERM-1:0] terminals,
  input wire logic selftest_ok,
  input wire logic monitor_block_output,
  input wire logic channel_fault,
  input wire logic discrepancy_fault,
  // read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic ch_a;
  logic ch_b;
  logic [7:0] hi_cnt;
  logic [7:0] ok_cnt;
  // channel levels on either terminal group in use
  assign ch_a = terminals[0] | terminals[12];
  assign ch_b = terminals[1] | terminals[17];
  // saturating run lengths of both-high inputs and passing self-test
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
      ok_cnt <= 8'h00;
    end else begin
      hi_cnt <= (ch_a && ch_b) ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
      ok_cnt <= selftest_ok ? ok_cnt + {7'h00, ok_cnt != 8'hff} : 8'h00;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  property p_run_gate;
    monitor_block_output |-> ok_cnt > SELFTEST + 1;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("output on before run");
  property p_out_filter;
    $rose(monitor_block_output) |-> hi_cnt >= FILTER_UNIT;
  endproperty
  a_out_filter: assert property (p_out_filter) else $error("output rose unfiltered");
  property p_ch_off;
    channel_fault |-> !monitor_block_output;
  endproperty
  a_ch_off: assert property (p_ch_off) else $error("output on with channel fault");
  property p_out_clean;
    monitor_block_output |-> !discrepancy_fault;
  endproperty
  a_out_clean: assert property (p_out_clean) else $error("output on with disc fault");
  property p_clear_out;
    $fell(channel_fault) |-> ##[0:2] monitor_block_output;
  endproperty
  a_clear_out: assert property (p_clear_out) else $error("clear without output");
  property p_clear_both;
    $fell(discrepancy_fault) |-> !channel_fault;
  endproperty
  a_clear_both: assert property (p_clear_both) else $error("faults cleared apart");
  property p_disc_time;
    $rose(discrepancy_fault) |-> $past(ch_a != ch_b, 16);
  endproperty
  a_disc_time: assert property (p_disc_time) else $error("disc fault too early");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
endmodule
bind dsm_monitor dsm_monitor_sva #(.FILTER_UNIT(FILTER_UNIT), .SELFTEST(SELFTEST)) u_sva (
  .clk, .rst_n, .terminals, .selftest_ok, .monitor_block_output, .channel_fault,
  .discrepancy_fault, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

// ---- dv/dsm_sw_model.sv ----
// two-contact switch or pulse-tested sensor on the terminals
`timescale 1ns/1ps
`default_nettype none
module dsm_sw_model (
  // clock and commands
  input wire logic clk,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic [4:0] idx_a,
  input wire logic [4:0] idx_b,
  input wire logic pulse_go,
  // terminal pins
  output logic [dsm_pkg::NUM_TERM-1:0] terminals
);
  logic [4:0] pulse_left = 5'h00;
  // test pulse holds channel a off for twelve cycles
  always @(posedge clk) begin
    if (pulse_go) pulse_left <= 5'h0c;
    else if (pulse_left != 5'h00) pulse_left <= pulse_left - 5'h01;
  end
  // contact b follows its command, contact a too except during a test pulse, idle pins pulled down
  always_comb begin
    terminals = '0;
    terminals[idx_a] = want_a && (pulse_left == 5'h00);
    terminals[idx_b] = want_b;
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the safety input monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_n, selftest_ok, want_a, want_b, pulse_go;
  logic [4:0] idx_a, idx_b;
  logic [dsm_pkg::NUM_TERM-1:0] terminals;
  logic monitor_block_output, channel_fault, discrepancy_fault, test_pulse_enable;
  logic [2:0] test_source_a, test_source_b;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count, n_tests;
  // ==========================================================
  // design and switch model
  dsm_monitor #(.FILTER_UNIT(4), .DISC_UNIT(10), .SELFTEST(16)) dut (
    .clk, .rst_n, .terminals, .selftest_ok, .monitor_block_output, .channel_fault,
    .discrepancy_fault, .test_source_a, .test_source_b, .test_pulse_enable,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  dsm_sw_model sw (.clk, .want_a, .want_b, .idx_a, .idx_b, .pulse_go, .terminals);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ta, tw, tr, done;
    logic [31:0] got;
    logic [1:0] resp;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(negedge clk);
      n++;
      {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
      got = s_axi_rdata;
      resp = w ? s_axi_bresp : s_axi_rresp;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end while (!done && n < 100);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    chk("resp", {30'h0, er}, {30'h0, resp});
    if (!w) chk("rdata", d, got);
  endtask
  task automatic set_ch(input logic a, input logic b, input int n);
    @(posedge clk);
    want_a <= a;
    want_b <= b;
    repeat (n) @(negedge clk);
  endtask
  task automatic see(input logic [2:0] e, input int max);
    int n;
    n = 0;
    while ({monitor_block_output, discrepancy_fault, channel_fault} !== e && n < max) begin
      @(negedge clk);
      n++;
    end
    chk("out_dcf_chf", {29'h0, e}, {29'h0, monitor_block_output, discrepancy_fault,
        channel_fault});
  endtask
  task automatic clr;
    set_ch(1'b0, 1'b0, 30);
    set_ch(1'b1, 1'b1, 0);
    see(3'b100, 40);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    selftest_ok = 1'b1;
    {want_a, want_b, pulse_go} = 3'b010;
    {idx_a, idx_b} = 10'h001;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (12) @(posedge clk);
    chk("src_b", 32'h1, {29'h0, test_source_b});
    rst_n <= 1'b1;
    bus(1'b0, dsm_pkg::OFF_CTRL, 32'h1000, 2'h0);
    bus(1'b0, dsm_pkg::OFF_TIMING, 32'h0201, 2'h0);
    bus(1'b0, dsm_pkg::OFF_SELECT, 32'h0100, 2'h0);
    bus(1'b0, dsm_pkg::OFF_FAULT, 32'h0, 2'h0);
    bus(1'b0, 8'h14, 32'h0, 2'h2);
    bus(1'b1, 8'h14, 32'hffffffff, 2'h2);
    see(3'b010, 80);
    clr;
    set_ch(1'b0, 1'b1, 14);
    set_ch(1'b1, 1'b1, 30);
    see(3'b001, 0);
    clr;
    set_ch(1'b0, 1'b1, 60);
    see(3'b010, 0);
    clr;
    set_ch(1'b0, 1'b1, 60);
    set_ch(1'b1, 1'b1, 20);
    see(3'b011, 0);
    clr;
    set_ch(1'b0, 1'b1, 3);
    set_ch(1'b1, 1'b1, 30);
    see(3'b100, 0);
    // discrepancy off: quick return, late return, stuck low
    bus(1'b1, dsm_pkg::OFF_TIMING, 32'h0001, 2'h0);
    for (int i = 0; i < 3; i++) begin
      set_ch(1'b0, 1'b1, (i == 0) ? 14 : 60);
      if (i < 2) set_ch(1'b1, 1'b1, 40);
      see(3'b000, 0);
      clr;
    end
    // mismatch at run entry after download, current then legacy
    set_ch(1'b0, 1'b1, 30);
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h1020, 2'h0);
    set_ch(1'b0, 1'b1, 60);
    see(3'b000, 0);
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h1030, 2'h0);
    set_ch(1'b0, 1'b1, 60);
    see(3'b001, 0);
    clr;
    set_ch(1'b0, 1'b1, 30);
    bus(1'b1, dsm_pkg::OFF_TIMING, 32'h0201, 2'h0);
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h1030, 2'h0);
    set_ch(1'b0, 1'b1, 60);
    see(3'b011, 0);
    clr;
    // pulse-tested pair blinks across run entry
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h1021, 2'h0);
    @(posedge clk);
    pulse_go <= 1'b1;
    @(posedge clk);
    pulse_go <= 1'b0;
    see(3'b100, 80);
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h1002, 2'h0);
    set_ch(1'b1, 1'b0, 60);
    see(3'b100, 0);
    set_ch(1'b1, 1'b1, 20);
    bus(1'b1, dsm_pkg::OFF_CTRL, 32'h5308, 2'h0);
    @(negedge clk);
    chk("pulse_src", 32'h5d, {25'h0, test_pulse_enable, test_source_a, test_source_b});
    bus(1'b1, dsm_pkg::OFF_SELECT, 32'h110c, 2'h0);
    bus(1'b0, dsm_pkg::OFF_SELECT, 32'h110c, 2'h0);
    @(posedge clk);
    idx_a <= 5'h0c;
    idx_b <= 5'h11;
    clr;
    bus(1'b1, dsm_pkg::OFF_TIMING, 32'h3f01, 2'h0);
    bus(1'b0, dsm_pkg::OFF_TIMING, 32'h3c01, 2'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
